// [logic/mem_ops_regs.svh]
`ifndef MEM_OPS_REGS_SVH
`define MEM_OPS_REGS_SVH

// data path width
`define DATA_W         8
// position of the top data bit, source of a left rotation
`define MSB_POS        7
// reset values of the architectural state held here
`define ACC_RESET      8'h00
`define CARRY_RESET    1'b0
`define ZERO_RESET     1'b0

`endif

// [logic/mem_ops_pkg.sv]
package mem_ops_pkg;

   // operations carried out by this datapath
   typedef enum logic [3:0] {
      op_none,
      move_mem_to_acc,
      move_acc_to_mem,
      or_into_acc,
      or_into_mem,
      rotate_left_mem,
      rotate_left_to_acc,
      rotate_left_carry_mem,
      rotate_left_carry_to_acc
   } op_t;

endpackage

// [logic/rotate_or_unit.sv]
`timescale 1ns/1ps
`include "mem_ops_regs.svh"

module rotate_or_unit (
   input  wire logic [`DATA_W-1:0] acc,
   input  wire logic [`DATA_W-1:0] mem,
   input  wire logic               carry_in,
   output logic      [`DATA_W-1:0] or_result,
   output logic      [`DATA_W-1:0] rot_plain,
   output logic      [`DATA_W-1:0] rot_carry,
   output logic                    carry_out,
   output logic                    or_zero
);

   // bitwise or and its zero detect
   assign or_result = acc | mem;
   assign or_zero   = (or_result == '0);

   // left rotations: plain feeds old top bit back, carry form feeds old carry
   assign rot_plain = {mem[`MSB_POS-1:0], mem[`MSB_POS]};
   assign rot_carry = {mem[`MSB_POS-1:0], carry_in};
   assign carry_out = mem[`MSB_POS];

endmodule

// [logic/mem_move_or_rotate_ops.sv]
`timescale 1ns/1ps
`include "mem_ops_regs.svh"

// Operation
// - move_mem_to_acc loads accumulator from memory byte; flags untouched.
// - move_acc_to_mem writes accumulator to memory; accumulator and flags kept.
// - or_into_acc puts acc OR memory into accumulator; only zero flag changes.
// - or_into_mem writes acc OR memory back to memory; only zero flag changes.
// - rotate_left_mem rotates memory left, bit 7 into bit 0; no flags.
// - rotate_left_to_acc puts left-rotated byte in accumulator; memory, flags kept.
// - rotate_left_carry_mem rotates memory through carry, writes back; carry gets bit 7.
// - rotate_left_carry_to_acc puts carry-rotated byte in accumulator; carry gets bit 7.
module mem_move_or_rotate_ops (
   input  wire logic               mclk,
   input  wire logic               reset_n,
   input  wire logic               op_valid,
   input  mem_ops_pkg::op_t        op,
   input  wire logic [`DATA_W-1:0] mem_rdata,
   output logic      [`DATA_W-1:0] acc_q,
   output logic                    carry_q,
   output logic                    zero_q,
   output logic                    mem_we_q,
   output logic      [`DATA_W-1:0] mem_wdata_q
);

   logic [`DATA_W-1:0] acc_d;
   logic               carry_d;
   logic               zero_d;
   logic               mem_we_d;
   logic [`DATA_W-1:0] mem_wdata_d;
   logic [`DATA_W-1:0] or_result;
   logic [`DATA_W-1:0] rot_plain;
   logic [`DATA_W-1:0] rot_carry;
   logic               carry_out;
   logic               or_zero;

   ////////////////////////////////////////////////////////////////////////////
   // shared combinational arithmetic
   rotate_or_unit u_rotate_or (
      .acc       (acc_q),
      .mem       (mem_rdata),
      .carry_in  (carry_q),
      .or_result (or_result),
      .rot_plain (rot_plain),
      .rot_carry (rot_carry),
      .carry_out (carry_out),
      .or_zero   (or_zero)
   );

   ////////////////////////////////////////////////////////////////////////////
   // accumulator group: only the to-accumulator ops load it
   always_comb begin
      acc_d = acc_q;
      if (op_valid) begin
         unique case (op)
            mem_ops_pkg::op_none: begin
               acc_d = acc_q;                                // no operation
            end
            mem_ops_pkg::move_mem_to_acc: begin
               acc_d = mem_rdata;
            end
            mem_ops_pkg::move_acc_to_mem: begin
               acc_d = acc_q;
            end
            mem_ops_pkg::or_into_acc: begin
               acc_d = or_result;
            end
            mem_ops_pkg::or_into_mem: begin
               acc_d = acc_q;
            end
            mem_ops_pkg::rotate_left_mem: begin
               acc_d = acc_q;
            end
            mem_ops_pkg::rotate_left_to_acc: begin
               acc_d = rot_plain;
            end
            mem_ops_pkg::rotate_left_carry_mem: begin
               acc_d = acc_q;
            end
            mem_ops_pkg::rotate_left_carry_to_acc: begin
               acc_d = rot_carry;
            end
            default: begin
               acc_d = acc_q;                                // illegal code: no effect
            end
         endcase
      end
   end

   // accumulator register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= `ACC_RESET;
      end else begin
         acc_q <= acc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag group: or ops touch zero only, carry rotates touch carry only
   always_comb begin
      carry_d = carry_q;
      zero_d  = zero_q;
      if (op_valid) begin
         unique case (op)
            mem_ops_pkg::op_none: begin
               carry_d = carry_q;                            // no operation
               zero_d  = zero_q;
            end
            mem_ops_pkg::move_mem_to_acc: begin
               carry_d = carry_q;
               zero_d  = zero_q;
            end
            mem_ops_pkg::move_acc_to_mem: begin
               carry_d = carry_q;
               zero_d  = zero_q;
            end
            mem_ops_pkg::or_into_acc: begin
               carry_d = carry_q;
               zero_d  = or_zero;
            end
            mem_ops_pkg::or_into_mem: begin
               carry_d = carry_q;
               zero_d  = or_zero;
            end
            mem_ops_pkg::rotate_left_mem: begin
               carry_d = carry_q;
               zero_d  = zero_q;
            end
            mem_ops_pkg::rotate_left_to_acc: begin
               carry_d = carry_q;
               zero_d  = zero_q;
            end
            mem_ops_pkg::rotate_left_carry_mem: begin
               carry_d = carry_out;
               zero_d  = zero_q;
            end
            mem_ops_pkg::rotate_left_carry_to_acc: begin
               carry_d = carry_out;
               zero_d  = zero_q;
            end
            default: begin
               carry_d = carry_q;                            // illegal code: no effect
               zero_d  = zero_q;
            end
         endcase
      end
   end

   // flag registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         carry_q <= `CARRY_RESET;
         zero_q  <= `ZERO_RESET;
      end else begin
         carry_q <= carry_d;
         zero_q  <= zero_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory write group: strobe lasts one cycle, data holds afterwards
   always_comb begin
      mem_we_d    = 1'b0;
      mem_wdata_d = mem_wdata_q;
      if (op_valid) begin
         unique case (op)
            mem_ops_pkg::op_none: begin
               mem_we_d = 1'b0;                              // no operation
            end
            mem_ops_pkg::move_mem_to_acc: begin
               mem_we_d = 1'b0;
            end
            mem_ops_pkg::move_acc_to_mem: begin
               mem_we_d    = 1'b1;
               mem_wdata_d = acc_q;
            end
            mem_ops_pkg::or_into_acc: begin
               mem_we_d = 1'b0;
            end
            mem_ops_pkg::or_into_mem: begin
               mem_we_d    = 1'b1;
               mem_wdata_d = or_result;
            end
            mem_ops_pkg::rotate_left_mem: begin
               mem_we_d    = 1'b1;
               mem_wdata_d = rot_plain;
            end
            mem_ops_pkg::rotate_left_to_acc: begin
               mem_we_d = 1'b0;
            end
            mem_ops_pkg::rotate_left_carry_mem: begin
               mem_we_d    = 1'b1;
               mem_wdata_d = rot_carry;
            end
            mem_ops_pkg::rotate_left_carry_to_acc: begin
               mem_we_d = 1'b0;
            end
            default: begin
               mem_we_d = 1'b0;                              // illegal code: no write
            end
         endcase
      end
   end

   // memory write registers; the caller keeps the address for one more cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mem_we_q    <= 1'b0;
         mem_wdata_q <= `ACC_RESET;
      end else begin
         mem_we_q    <= mem_we_d;
         mem_wdata_q <= mem_wdata_d;
      end
   end

endmodule

// [verification/mem_ops_sva.sv]
`timescale 1ns/1ps
module mem_ops_sva (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       op_valid,
   input mem_ops_pkg::op_t op,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] acc_q,
   input wire logic       carry_q,
   input wire logic       zero_q,
   input wire logic       mem_we_q,
   input wire logic [7:0] mem_wdata_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [7:0] m_q;
   logic       c_q;
   // operands as seen at the taking edge
   always_ff @(posedge mclk) begin
      m_q <= mem_rdata;
      c_q <= carry_q;
   end
   sequence s_op(mem_ops_pkg::op_t k);
      op_valid && op == k;
   endsequence
   ////////////////////////////////////////////////////////////
   a_move_to_acc: assert property (s_op(mem_ops_pkg::move_mem_to_acc) |=> acc_q == m_q
      && $stable({carry_q, zero_q}) && !mem_we_q) else $error("move to acc wrong");
   a_move_to_mem: assert property (s_op(mem_ops_pkg::move_acc_to_mem) |=> mem_we_q
      && mem_wdata_q == acc_q && $stable({acc_q, carry_q, zero_q})) else $error("move wrong");
   a_or_acc_zero: assert property (s_op(mem_ops_pkg::or_into_acc) |=> $stable(carry_q)
      && zero_q == (acc_q == 8'h00) && !mem_we_q) else $error("or acc wrong");
   a_or_mem_zero: assert property (s_op(mem_ops_pkg::or_into_mem) |=> mem_we_q
      && $stable(acc_q) && zero_q == (mem_wdata_q == 8'h00)) else $error("or mem wrong");
   a_rotate_mem: assert property (s_op(mem_ops_pkg::rotate_left_mem) |=> mem_we_q
      && mem_wdata_q == {m_q[6:0], m_q[7]} && $stable({acc_q, carry_q, zero_q}))
      else $error("rotate mem wrong");
   a_rotate_acc: assert property (s_op(mem_ops_pkg::rotate_left_to_acc) |=> !mem_we_q
      && acc_q == {m_q[6:0], m_q[7]} && $stable({carry_q, zero_q})) else $error("rot acc wrong");
   a_carry_mem: assert property (s_op(mem_ops_pkg::rotate_left_carry_mem) |=> mem_we_q
      && {carry_q, mem_wdata_q} == {m_q, c_q} && $stable(zero_q)) else $error("rlc mem wrong");
   a_carry_acc: assert property (s_op(mem_ops_pkg::rotate_left_carry_to_acc) |=>
      !mem_we_q && {carry_q, acc_q} == {m_q, c_q}) else $error("rlc acc wrong");
endmodule
bind mem_move_or_rotate_ops mem_ops_sva u_mem_ops_sva (.mclk, .reset_n, .op_valid, .op,
   .mem_rdata, .acc_q, .carry_q, .zero_q, .mem_we_q, .mem_wdata_q);

// [verification/tb_mem_move_or_rotate_ops.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_mem_move_or_rotate_ops;
   logic             mclk = 0;
   logic             reset_n = 0;
   logic             op_valid = 0;
   mem_ops_pkg::op_t op = mem_ops_pkg::op_none;
   logic [7:0]       mem_rdata = 8'h00;
   logic [7:0]       acc_q, mem_wdata_q;
   logic             carry_q, zero_q, mem_we_q;
   int               bad_count = 0;
   int               cmp_count = 0;
   always #2 mclk = ~mclk;
   mem_move_or_rotate_ops u_mem_move_or_rotate_ops (.mclk, .reset_n, .op_valid, .op,
      .mem_rdata, .acc_q, .carry_q, .zero_q, .mem_we_q, .mem_wdata_q);
   // one op for one edge; results sampled while the write strobe stands
   task op1(mem_ops_pkg::op_t k, logic [7:0] m);
      @(negedge mclk);
      op_valid = 1;
      op = k;
      mem_rdata = m;
      @(negedge mclk);
      op_valid = 0;
   endtask
   task t_move;
      op1(mem_ops_pkg::move_mem_to_acc, 8'hA5);
      `CHK({mem_we_q, acc_q}, 9'h0A5)
      op1(mem_ops_pkg::move_acc_to_mem, 8'h3C);
      `CHK({mem_we_q, mem_wdata_q, acc_q}, 17'h1A5A5)
   endtask
   task t_or;
      op1(mem_ops_pkg::or_into_acc, 8'h0A);
      `CHK({zero_q, acc_q}, 9'h0AF)
      op1(mem_ops_pkg::or_into_mem, 8'h50);
      `CHK({mem_we_q, zero_q, mem_wdata_q, acc_q}, 18'h2FFAF)
      op1(mem_ops_pkg::move_mem_to_acc, 8'h00);
      op1(mem_ops_pkg::or_into_mem, 8'h00);
      `CHK({mem_we_q, zero_q, mem_wdata_q}, 10'h300)
      op1(mem_ops_pkg::or_into_acc, 8'h00);
      `CHK({zero_q, acc_q}, 9'h100)
   endtask
   task t_rot;
      op1(mem_ops_pkg::rotate_left_mem, 8'h81);
      `CHK({mem_we_q, mem_wdata_q, acc_q}, 17'h10300)
      op1(mem_ops_pkg::rotate_left_to_acc, 8'hC0);
      `CHK({mem_we_q, acc_q}, 9'h081)
   endtask
   task t_carry;
      op1(mem_ops_pkg::rotate_left_carry_mem, 8'h81);
      `CHK({mem_we_q, carry_q, mem_wdata_q}, 10'h302)
      op1(mem_ops_pkg::rotate_left_carry_to_acc, 8'h40);
      `CHK({zero_q, carry_q, acc_q}, 10'h281)
   endtask
   // back to back ops with valid held, then an idle op that must change nothing
   task t_b2b;
      @(negedge mclk);
      op_valid = 1;
      op = mem_ops_pkg::move_mem_to_acc;
      mem_rdata = 8'h12;
      @(negedge mclk);
      op = mem_ops_pkg::or_into_mem;
      mem_rdata = 8'h21;
      @(negedge mclk);
      op_valid = 0;
      `CHK({mem_we_q, zero_q, mem_wdata_q, acc_q}, 18'h23312)
      op1(mem_ops_pkg::op_none, 8'hFF);
      `CHK({mem_we_q, zero_q, carry_q, mem_wdata_q, acc_q}, 19'h03312)
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge mclk);
      @(negedge mclk) reset_n = 1;
      t_move;
      t_or;
      t_rot;
      t_carry;
      t_b2b;
      results;
   end
   // watchdog against a hung run
   initial begin
      #2000;
      bad_count++;
      results;
   end
endmodule
